// ===== shared/pti_pkg.sv
package pti_pkg;

    // Clock and timing
    localparam longint CLK_HZ          = 10_000_000;
    localparam int     CLK_PERIOD_NS   = 100;
    localparam int     FILT_TICK_MS    = 10;
    localparam int     FILT_TICK_CYC   = int'((CLK_HZ / 1000) * FILT_TICK_MS);
    localparam int     MEAS_CNT_W      = 24;
    localparam int     DIV_W           = 40;
    localparam longint FREQ_NUM        = CLK_HZ * 1000;
    localparam longint NCO_MOD         = CLK_HZ * 500;

    // Register byte offsets
    localparam logic [5:0] OFS_IN_CFG    = 6'h00;
    localparam logic [5:0] OFS_IN_SCALE  = 6'h04;
    localparam logic [5:0] OFS_IN_GAIN   = 6'h08;
    localparam logic [5:0] OFS_IN_BIAS   = 6'h0C;
    localparam logic [5:0] OFS_FILT_TIME = 6'h10;
    localparam logic [5:0] OFS_MAX_FREQ  = 6'h14;
    localparam logic [5:0] OFS_OUT_SRC   = 6'h18;
    localparam logic [5:0] OFS_OUT_SCALE = 6'h1C;
    localparam logic [5:0] OFS_MON_PCT   = 6'h20;
    localparam logic [5:0] OFS_STATUS    = 6'h24;
    localparam logic [5:0] OFS_IRQ_STAT  = 6'h28;
    localparam logic [5:0] OFS_IRQ_MASK  = 6'h2C;
    localparam logic [5:0] OFS_FREQ_REF  = 6'h30;

    // Input configuration word, bits [13:0]
    typedef struct packed {
        logic [3:0] pid_mode;
        logic [3:0] fb_src;
        logic [3:0] ref_src;
        logic [1:0] in_func;
    } pti_in_cfg_t;

    localparam pti_in_cfg_t RST_IN_CFG = '{4'h0, 4'h0, 4'h4, 2'h0};
    localparam logic [15:0] RST_IN_SCALE  = 16'h2710;
    localparam logic [13:0] RST_IN_GAIN   = 14'h03E8;
    localparam logic [15:0] RST_IN_BIAS   = 16'h0000;
    localparam logic [7:0]  RST_FILT_TIME = 8'h0A;
    localparam logic [15:0] RST_MAX_FREQ  = 16'h1770;
    localparam logic [2:0]  RST_OUT_SRC   = 3'h2;
    localparam logic [15:0] RST_OUT_SCALE = 16'h2710;

    // Selection codes
    localparam logic [1:0] IN_FUNC_GENERAL = 2'h0;
    localparam logic [1:0] IN_FUNC_DUTY    = 2'h1;
    localparam logic [1:0] IN_FUNC_TARGET  = 2'h2;
    localparam logic [3:0] REF_SRC_PULSE   = 4'h4;
    localparam logic [3:0] REF_SRC_PID     = 4'h5;
    localparam logic [3:0] FB_SRC_PULSE    = 4'h3;
    localparam logic [2:0] OUT_OUT_FREQ    = 3'h2;
    localparam logic [2:0] OUT_ENCODER     = 3'h7;

    // Ranges, percentages in 0.1 % steps
    localparam logic [15:0] GEN_SCALE_MIN  = 16'h0032;
    localparam logic [15:0] GEN_SCALE_MAX  = 16'h7D00;
    localparam logic [15:0] DUTY_SCALE_MIN = 16'h000A;
    localparam logic [15:0] DUTY_SCALE_MAX = 16'h03E8;
    localparam logic [13:0] GAIN_MAX       = 14'h2710;
    localparam logic [15:0] BIAS_MAX_ABS   = 16'h03E8;
    localparam logic [7:0]  FILT_MAX       = 8'hC8;
    localparam logic [15:0] OUT_SCALE_MAX  = 16'h7D00;
    localparam logic [15:0] PCT_FULL       = 16'h03E8;
    localparam logic [15:0] PCT_MAX        = 16'h2710;
    localparam logic [15:0] DUTY_BAND_LO   = 16'h007D;
    localparam logic [15:0] DUTY_BAND_HI   = 16'h036B;

    // Interrupt bits
    localparam int IRQ_W    = 3;
    localparam int IRQ_MEAS = 0;
    localparam int IRQ_CFG  = 1;
    localparam int IRQ_LOST = 2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FREQ  = 2'b01,
        ST_DUTY  = 2'b11,
        ST_APPLY = 2'b10
    } pti_calc_st_t;

endpackage

// ===== hw/pti_top.sv
`timescale 1ns/100ps

module pti_top
    import pti_pkg::*;
#(
    parameter int FILT_TICK = FILT_TICK_CYC,
    parameter int CNT_W     = MEAS_CNT_W
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic        train_input_terminal,
    input  wire logic        encoder_feedback_card,
    input  wire logic        fwd_cmd_in,
    input  wire logic        rev_cmd_in,
    input  wire logic [15:0] freq_cmd_pct,
    input  wire logic [15:0] out_freq_pct,
    input  wire logic [15:0] soft_start_pct,
    input  wire logic [15:0] motor_speed_pct,
    input  wire logic [15:0] pid_fb_pct,
    input  wire logic [15:0] pid_in_pct,
    input  wire logic [15:0] drive_out_freq,
    output logic             train_output_terminal,
    output logic [19:0]      freq_ref,
    output logic             freq_ref_sel,
    output logic [15:0]      pid_value,
    output logic             pid_fb_sel,
    output logic             pid_target_sel,
    output logic             pulse_config_error_code,
    output logic             dir_fwd,
    output logic             dir_rev
);

    function automatic logic hit(input logic [3:0] a, input logic [5:0] ofs);
        hit = (a == ofs[5:2]);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = (old & ~m) | (wd & m);
    endfunction

    function automatic logic scale_ok(input logic [1:0] f, input logic [15:0] v);
        if (f == IN_FUNC_DUTY)
            scale_ok = (v >= DUTY_SCALE_MIN) && (v <= DUTY_SCALE_MAX);
        else
            scale_ok = (v >= GEN_SCALE_MIN) && (v <= GEN_SCALE_MAX);
    endfunction

    function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lim);
        clamp16 = (v > {16'h0000, lim}) ? lim : v[15:0];
    endfunction

    // Registers
    pti_in_cfg_t  cfg_r;
    logic [15:0]  in_scale_r;
    logic [13:0]  gain_r;
    logic [15:0]  bias_r;
    logic [7:0]   filt_time_r;
    logic [15:0]  max_freq_r;
    logic [2:0]   out_src_r;
    logic [15:0]  out_scale_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic         wait_r;
    logic [31:0]  rdata_r;
    logic         irq_r;

    // Bus decode
    wire wr_go = avs_write & ~wait_r;
    wire rd_go = avs_read & ~wait_r;
    wire [31:0] wd_cfg   = merge({18'h00000, cfg_r}, avs_writedata, avs_byteenable);
    wire [31:0] wd_scale = merge({16'h0000, in_scale_r}, avs_writedata, avs_byteenable);
    wire [31:0] wd_gain  = merge({18'h00000, gain_r}, avs_writedata, avs_byteenable);
    wire [31:0] wd_bias  = merge({16'h0000, bias_r}, avs_writedata, avs_byteenable);
    wire [31:0] wd_filt  = merge({24'h000000, filt_time_r}, avs_writedata, avs_byteenable);
    wire [31:0] wd_maxf  = merge({16'h0000, max_freq_r}, avs_writedata, avs_byteenable);
    wire [31:0] wd_osrc  = merge({29'h00000000, out_src_r}, avs_writedata, avs_byteenable);
    wire [31:0] wd_oscl  = merge({16'h0000, out_scale_r}, avs_writedata, avs_byteenable);
    wire [31:0] wd_mask  = merge({29'h00000000, irq_mask_r}, avs_writedata, avs_byteenable);
    wire [31:0] wd_clr   = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire pti_in_cfg_t new_cfg = pti_in_cfg_t'(wd_cfg[13:0]);
    wire bias_neg = wd_bias[15];
    wire [15:0] bias_abs = bias_neg ? (16'h0000 - wd_bias[15:0]) : wd_bias[15:0];
    wire gain_ok  = wd_gain[13:0] <= GAIN_MAX;
    wire bias_ok  = bias_abs <= BIAS_MAX_ABS;
    wire filt_ok  = wd_filt[7:0] <= FILT_MAX;
    wire osrc_ok  = wd_osrc[2:0] != 3'h0;
    wire oscl_ok  = wd_oscl[15:0] <= OUT_SCALE_MAX;
    wire cfg_ok   = scale_ok(new_cfg.in_func, in_scale_r) && (new_cfg.in_func != 2'h3);

    // Input synchronisers
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic       in_d_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            in_d_r  <= 1'b0;
        end else begin
            sync1_r <= {rev_cmd_in, fwd_cmd_in, encoder_feedback_card, train_input_terminal};
            sync2_r <= sync1_r;
            in_d_r  <= sync2_r[0];
        end
    end
    wire in_s   = sync2_r[0];
    wire enc_s  = sync2_r[1];
    wire fwd_s  = sync2_r[2];
    wire rev_s  = sync2_r[3];
    wire rise   = in_s & ~in_d_r;
    wire fall   = ~in_s & in_d_r;

    // Period and high-time counting
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] high_r;
    logic             seen_r;
    logic             lost_r;
    wire cnt_full = &cnt_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r    <= '0;
            period_r <= '0;
            high_r   <= '0;
            seen_r   <= 1'b0;
            lost_r   <= 1'b1;
        end else begin
            if (rise) begin
                cnt_r    <= '0;
                period_r <= cnt_r + 1'b1;
                seen_r   <= 1'b1;
                lost_r   <= ~seen_r;
            end else if (cnt_full) begin
                seen_r <= 1'b0;
                lost_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
            if (fall)
                high_r <= cnt_r + 1'b1;
        end
    end

    // Shared serial divider, frequency first then duty
    pti_calc_st_t     st_r;
    logic [DIV_W-1:0] quo_r;
    logic [DIV_W:0]   rem_r;
    logic [DIV_W-1:0] den_r;
    logic [5:0]       bit_r;
    logic [15:0]      freq_pct_r;
    logic [15:0]      duty_pct_r;
    logic             meas_ev_r;
    wire [DIV_W:0]   trial   = {rem_r[DIV_W-1:0], quo_r[DIV_W-1]};
    wire             fits    = trial >= {1'b0, den_r};
    wire [DIV_W:0]   rem_nxt = fits ? (trial - {1'b0, den_r}) : trial;
    wire [DIV_W-1:0] quo_nxt = {quo_r[DIV_W-2:0], fits};
    wire             div_end = (bit_r == 6'h00);
    // Period of the rise just seen, not the stored one, which lags a period
    wire [DIV_W-1:0] freq_den = (DIV_W'(cnt_r) + 1'b1) * DIV_W'(in_scale_r);
    wire [DIV_W-1:0] duty_num = DIV_W'(high_r) * DIV_W'(PCT_FULL);
    wire [15:0]      quo_pct  = (|quo_r[DIV_W-1:16]) ? PCT_MAX : clamp16({16'h0000, quo_r[15:0]}, PCT_MAX);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r       <= ST_IDLE;
            quo_r      <= '0;
            rem_r      <= '0;
            den_r      <= '0;
            bit_r      <= 6'h00;
            freq_pct_r <= 16'h0000;
            duty_pct_r <= 16'h0000;
            meas_ev_r  <= 1'b0;
        end else begin
            meas_ev_r <= 1'b0;
            unique case (st_r)
                ST_IDLE: if (rise && seen_r) begin
                    st_r  <= ST_FREQ;
                    quo_r <= DIV_W'(FREQ_NUM);
                    rem_r <= '0;
                    den_r <= freq_den;
                    bit_r <= 6'(DIV_W - 1);
                end
                ST_FREQ: begin
                    quo_r <= quo_nxt;
                    rem_r <= rem_nxt;
                    bit_r <= bit_r - 6'h01;
                    if (div_end) begin
                        st_r <= ST_DUTY;
                        freq_pct_r <= ((|quo_nxt[DIV_W-1:16]) ? PCT_MAX
                                       : clamp16({16'h0000, quo_nxt[15:0]}, PCT_MAX));
                        quo_r <= duty_num;
                        rem_r <= '0;
                        den_r <= DIV_W'(period_r);
                        bit_r <= 6'(DIV_W - 1);
                    end
                end
                ST_DUTY: begin
                    quo_r <= quo_nxt;
                    rem_r <= rem_nxt;
                    bit_r <= bit_r - 6'h01;
                    if (div_end)
                        st_r <= ST_APPLY;
                end
                ST_APPLY: begin
                    duty_pct_r <= quo_pct;
                    meas_ev_r  <= 1'b1;
                    st_r       <= ST_IDLE;
                end
            endcase
        end
    end

    // Activity, monitor and gain/bias
    wire duty_mode = cfg_r.in_func == IN_FUNC_DUTY;
    wire duty_in_band = (duty_pct_r >= DUTY_BAND_LO) && (duty_pct_r <= DUTY_BAND_HI);
    wire active     = ~lost_r && (~duty_mode || duty_in_band);
    wire [15:0] raw_pct = active ? freq_pct_r : 16'h0000;
    wire [15:0] mon_pct = duty_mode ? duty_pct_r : freq_pct_r;
    wire [31:0] gained  = (32'(raw_pct) * 32'(gain_r)) / 32'(PCT_FULL);
    wire [31:0] biased  = gained + {{16{bias_r[15]}}, bias_r};
    wire [15:0] scaled_pct = biased[31] ? 16'h0000 : clamp16(biased, PCT_MAX);

    // Low-pass filter, one step per tick; a filter time of 0 passes scaled_pct through every cycle
    logic [31:0] tick_r;
    logic [15:0] filt_r;
    wire        tick    = (tick_r == 32'(FILT_TICK - 1));
    wire        up      = scaled_pct >= filt_r;
    wire [15:0] diff    = up ? (scaled_pct - filt_r) : (filt_r - scaled_pct);
    wire [15:0] quot    = diff / (16'(filt_time_r) + 16'h0001);
    wire [15:0] stepv   = ((quot == 16'h0000) && (diff != 16'h0000)) ? 16'h0001 : quot;
    wire [15:0] filt_nxt = up ? (filt_r + stepv) : (filt_r - stepv);
    wire [31:0] ref_nxt  = (32'(filt_r) * 32'(max_freq_r)) / 32'(PCT_FULL);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_r <= 32'h00000000;
            filt_r <= 16'h0000;
        end else begin
            tick_r <= tick ? 32'h00000000 : tick_r + 32'h00000001;
            if (filt_time_r == 8'h00)
                filt_r <= scaled_pct;
            else if (tick)
                filt_r <= filt_nxt;
        end
    end

    // Routing and configuration checks
    wire sel_ref = (cfg_r.ref_src == REF_SRC_PULSE) && (cfg_r.in_func == IN_FUNC_GENERAL);
    wire sel_fb  = (cfg_r.ref_src == REF_SRC_PID) && duty_mode
                   && (cfg_r.fb_src == FB_SRC_PULSE);
    wire sel_tg  = (cfg_r.ref_src == REF_SRC_PID) && (cfg_r.in_func == IN_FUNC_TARGET);
    wire err_a   = duty_mode && (cfg_r.fb_src != FB_SRC_PULSE);
    wire err_b   = (cfg_r.in_func == IN_FUNC_GENERAL) && (cfg_r.pid_mode != 4'h0);
    wire cfg_err = err_a | err_b;
    logic cfg_err_r;
    logic lost_d_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_ref       <= 20'h00000;
            freq_ref_sel   <= 1'b0;
            pid_value      <= 16'h0000;
            pid_fb_sel     <= 1'b0;
            pid_target_sel <= 1'b0;
            cfg_err_r      <= 1'b0;
            lost_d_r       <= 1'b1;
            dir_fwd        <= 1'b0;
            dir_rev        <= 1'b0;
        end else begin
            freq_ref       <= sel_ref ? ref_nxt[19:0] : 20'h00000;
            freq_ref_sel   <= sel_ref;
            pid_value      <= filt_r;
            pid_fb_sel     <= sel_fb;
            pid_target_sel <= sel_tg;
            cfg_err_r      <= cfg_err;
            lost_d_r       <= ~active;
            dir_fwd        <= fwd_s & ~rev_s;
            dir_rev        <= rev_s & ~fwd_s;
        end
    end
    assign pulse_config_error_code = cfg_err_r;

    // Pulse output generator
    logic [15:0] src_pct;
    always_comb begin
        unique case (out_src_r)
            3'h1:    src_pct = freq_cmd_pct;
            3'h2:    src_pct = out_freq_pct;
            3'h3:    src_pct = soft_start_pct;
            3'h4:    src_pct = motor_speed_pct;
            3'h5:    src_pct = pid_fb_pct;
            3'h6:    src_pct = pid_in_pct;
            default: src_pct = 16'h0000;
        endcase
    end
    wire [15:0] out_pct   = clamp16({16'h0000, src_pct}, PCT_FULL);
    wire        sync_mode = (out_src_r == OUT_OUT_FREQ) && (out_scale_r == 16'h0000);
    wire [33:0] nco_step  = sync_mode ? (34'(drive_out_freq) * 34'h000000000A)
                                      : (34'(out_scale_r) * 34'(out_pct));
    logic [33:0] acc_r;
    logic        nco_r;
    logic        po_r;
    wire [33:0] acc_sum = acc_r + nco_step;
    wire        wrap    = acc_sum >= 34'(NCO_MOD);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= 34'h000000000;
            nco_r <= 1'b0;
            po_r  <= 1'b0;
        end else begin
            acc_r <= wrap ? (acc_sum - 34'(NCO_MOD)) : acc_sum;
            nco_r <= wrap ? ~nco_r : nco_r;
            po_r  <= (out_src_r == OUT_ENCODER) ? enc_s : nco_r;
        end
    end
    assign train_output_terminal = po_r;

    // Register file and Avalon slave, one wait state per access
    wire [IRQ_W-1:0] irq_ev = {lost_d_r == 1'b0 && active == 1'b0,
                               cfg_err & ~cfg_err_r, meas_ev_r};
    wire [IRQ_W-1:0] clr    = (wr_go && hit(avs_address, OFS_IRQ_STAT)) ? wd_clr[IRQ_W-1:0]
                                                                         : '0;
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (hit(avs_address, OFS_IN_CFG))    rd_mux = {18'h00000, cfg_r};
        if (hit(avs_address, OFS_IN_SCALE))  rd_mux = {16'h0000, in_scale_r};
        if (hit(avs_address, OFS_IN_GAIN))   rd_mux = {18'h00000, gain_r};
        if (hit(avs_address, OFS_IN_BIAS))   rd_mux = {16'h0000, bias_r};
        if (hit(avs_address, OFS_FILT_TIME)) rd_mux = {24'h000000, filt_time_r};
        if (hit(avs_address, OFS_MAX_FREQ))  rd_mux = {16'h0000, max_freq_r};
        if (hit(avs_address, OFS_OUT_SRC))   rd_mux = {29'h00000000, out_src_r};
        if (hit(avs_address, OFS_OUT_SCALE)) rd_mux = {16'h0000, out_scale_r};
        if (hit(avs_address, OFS_MON_PCT))   rd_mux = {16'h0000, mon_pct};
        if (hit(avs_address, OFS_STATUS))    rd_mux = {29'h00000000, cfg_err_r, active, seen_r};
        if (hit(avs_address, OFS_IRQ_STAT))  rd_mux = {29'h00000000, irq_stat_r};
        if (hit(avs_address, OFS_IRQ_MASK))  rd_mux = {29'h00000000, irq_mask_r};
        if (hit(avs_address, OFS_FREQ_REF))  rd_mux = {12'h000, freq_ref};
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r       <= RST_IN_CFG;
            in_scale_r  <= RST_IN_SCALE;
            gain_r      <= RST_IN_GAIN;
            bias_r      <= RST_IN_BIAS;
            filt_time_r <= RST_FILT_TIME;
            max_freq_r  <= RST_MAX_FREQ;
            out_src_r   <= RST_OUT_SRC;
            out_scale_r <= RST_OUT_SCALE;
            irq_mask_r  <= '0;
        end else if (wr_go) begin
            // Out-of-range values are dropped; setups that raise cfg_err are still stored
            if (hit(avs_address, OFS_IN_CFG) && cfg_ok)     cfg_r <= new_cfg;
            if (hit(avs_address, OFS_IN_SCALE) && scale_ok(cfg_r.in_func, wd_scale[15:0]))
                in_scale_r <= wd_scale[15:0];
            if (hit(avs_address, OFS_IN_GAIN) && gain_ok)   gain_r <= wd_gain[13:0];
            if (hit(avs_address, OFS_IN_BIAS) && bias_ok)   bias_r <= wd_bias[15:0];
            if (hit(avs_address, OFS_FILT_TIME) && filt_ok) filt_time_r <= wd_filt[7:0];
            if (hit(avs_address, OFS_MAX_FREQ))             max_freq_r <= wd_maxf[15:0];
            if (hit(avs_address, OFS_OUT_SRC) && osrc_ok)   out_src_r <= wd_osrc[2:0];
            if (hit(avs_address, OFS_OUT_SCALE) && oscl_ok) out_scale_r <= wd_oscl[15:0];
            if (hit(avs_address, OFS_IRQ_MASK))             irq_mask_r <= wd_mask[IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r     <= 1'b1;
            rdata_r    <= 32'h00000000;
            irq_stat_r <= '0;
            irq_r      <= 1'b0;
        end else begin
            wait_r     <= ~((avs_read | avs_write) & wait_r);
            rdata_r    <= ((avs_read | avs_write) & wait_r) ? rd_mux : rdata_r;
            // Set beats clear in the same cycle
            irq_stat_r <= (irq_stat_r & ~clr) | irq_ev;
            irq_r      <= |(irq_stat_r & irq_mask_r);
        end
    end
    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign irq             = irq_r;

endmodule

// ===== bench/pti_top_asserts.sv
`timescale 1ns/100ps
module pti_top_asserts (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic        fwd_cmd_in,
    input wire logic        rev_cmd_in,
    input wire logic [19:0] freq_ref,
    input wire logic        freq_ref_sel,
    input wire logic        pid_fb_sel,
    input wire logic        pid_target_sel,
    input wire logic        pulse_config_error_code,
    input wire logic        dir_fwd,
    input wire logic        dir_rev
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_req; $rose(avs_read || avs_write); endsequence
    sequence s_ans; avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest; endsequence
    a_bus_one_wait: assert property (s_req |-> s_ans)
        else $error("wait state count wrong");
    a_bus_ans_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    // Five cycles covers sync flops plus output register
    a_dir_fwd_on: assert property ((fwd_cmd_in && !rev_cmd_in) [*5] |-> dir_fwd)
        else $error("forward not followed");
    a_dir_rev_on: assert property ((rev_cmd_in && !fwd_cmd_in) [*5] |-> dir_rev)
        else $error("reverse not followed");
    a_dir_excl: assert property (!(dir_fwd && dir_rev))
        else $error("both directions");
    a_sel_excl: assert property ($onehot0({freq_ref_sel, pid_fb_sel, pid_target_sel}))
        else $error("two destinations");
    a_ref_zero: assert property (!freq_ref_sel |-> freq_ref == 20'h00000)
        else $error("reference not idle");
    a_cfg_clean: assert property ((pid_fb_sel || pid_target_sel) |-> !pulse_config_error_code)
        else $error("error on valid setup");
endmodule
bind pti_top pti_top_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .fwd_cmd_in(fwd_cmd_in),
    .rev_cmd_in(rev_cmd_in), .freq_ref(freq_ref), .freq_ref_sel(freq_ref_sel),
    .pid_fb_sel(pid_fb_sel), .pid_target_sel(pid_target_sel), .dir_fwd(dir_fwd),
    .pulse_config_error_code(pulse_config_error_code), .dir_rev(dir_rev));

// ===== bench/pti_pulse_src.sv
`timescale 1ns/100ps
module pti_pulse_src (
    input  wire logic        ref_clk,
    input  wire logic        en,
    input  wire logic [15:0] period,
    input  wire logic [15:0] high,
    output logic             pulse
);
    logic [15:0] cnt_r;
    // Parked low when stopped, so no stray rise reaches the input
    always @(posedge ref_clk) begin
        cnt_r <= (!en || cnt_r >= period - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
        pulse <= en && (cnt_r < high);
    end
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import pti_pkg::*;
    logic        ref_clk, rst_n, rd, wr, ws, irq, pin, enc, fwd, rev, pen, po, frs, fbs, tgs;
    logic        cfe, df, dr;
    logic [3:0]  adr;
    logic [31:0] wd, rdat, q;
    logic [15:0] ph, g, pidv;
    logic [15:0] pct [6];
    logic [19:0] fref;
    int          mismatches, cmp_count, k;
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    pti_pulse_src src (.ref_clk(ref_clk), .en(pen), .period(16'h09C4), .high(ph), .pulse(pin));
    pti_top #(.FILT_TICK(20), .CNT_W(12)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(ws), .irq(irq),
        .train_input_terminal(pin), .encoder_feedback_card(enc), .fwd_cmd_in(fwd),
        .rev_cmd_in(rev), .freq_cmd_pct(pct[0]), .out_freq_pct(pct[1]),
        .soft_start_pct(pct[2]), .motor_speed_pct(pct[3]), .pid_fb_pct(pct[4]),
        .pid_in_pct(pct[5]), .drive_out_freq(pct[0]), .train_output_terminal(po),
        .freq_ref(fref), .freq_ref_sel(frs), .pid_value(pidv), .pid_fb_sel(fbs),
        .pid_target_sel(tgs), .pulse_config_error_code(cfe), .dir_fwd(df), .dir_rev(dr));
    function automatic logic [19:0] exp_ref(input int p);
        return 20'(p * int'(RST_MAX_FREQ) / 1000);
    endfunction
    task automatic results();
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s exp %0h got %0h", nm, e, s);
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ws !== 1'b0 && n < 99);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 99) begin
            mismatches++;
            results();
        end
        @(posedge ref_clk);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
        bus(a, 1'b0, 32'h0);
        chk(nm, q, e);
    endtask
    task automatic cfg(input logic [31:0] d);
        bus(4'h0, 1'b1, d);
        repeat (2) @(posedge ref_clk);
    endtask
    // Two completed measurements, so the first may predate new settings
    task automatic meas();
        int m;
        for (int i = 0; i < 2; i++) begin
            bus(4'hA, 1'b1, 32'h1);
            m = 0;
            do begin
                bus(4'hA, 1'b0, 32'h0);
                m++;
            end while (q[0] !== 1'b1 && m < 9999);
            if (m >= 9999) begin
                mismatches++;
                results();
            end
        end
    endtask
    initial begin
        {rst_n, rd, wr, enc, fwd, rev, pen, adr, wd} = '0;
        ph = 16'h04E2;
        void'($urandom(1));
        foreach (pct[i]) pct[i] = 16'($urandom_range(1000));
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rc(4'h0, 32'h10, "in_cfg");
        rc(4'hF, 32'h0, "unmapped");
        bus(4'h1, 1'b1, 32'h31);
        rc(4'h1, 32'h2710, "scale_low");
        bus(4'h1, 1'b1, 32'hFA0);
        bus(4'h4, 1'b1, 32'h0);
        pen <= 1'b1;
        meas();
        rc(4'h8, 32'h3E8, "mon_pct");
        chk("freq_ref", fref, exp_ref(1000));
        g = 16'h01F4 + 16'($urandom_range(1000));
        bus(4'h2, 1'b1, g);
        bus(4'h3, 1'b1, 32'hFF9C);
        meas();
        chk("pid_value", pidv, g - 16'h0064);
        chk("freq_ref_g", fref, exp_ref(int'(g) - 100));
        bus(4'h1, 1'b1, 32'h3E8);
        cfg(32'h15);
        chk("cfg_err_fb", cfe, 1);
        cfg(32'hD5);
        chk("fb_sel", {cfe, fbs}, 2'b01);
        ph <= 16'h0271;
        meas();
        rc(4'h8, 32'hFA, "duty_pct");
        ph <= 16'h007D;
        meas();
        rc(4'h9, 32'h1, "inactive");
        cfg(32'h410);
        chk("cfg_err_pid", cfe, 1);
        cfg(32'h16);
        chk("tgt_sel", {cfe, tgs, frs}, 3'b010);
        meas();
        pen <= 1'b0;
        bus(4'hB, 1'b1, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("irq_on", irq, 1);
        bus(4'hA, 1'b1, 32'h7);
        repeat (2) @(posedge ref_clk);
        chk("irq_clr", irq, 0);
        bus(4'hB, 1'b1, 32'h4);
        k = 0;
        while (irq !== 1'b1 && k < 6000) begin
            @(posedge ref_clk);
            k++;
        end
        chk("irq_lost", irq, 1);
        bus(4'h7, 1'b1, 32'h7D00);
        bus(4'h6, 1'b1, 32'h1);
        k = 0;
        q[0] = po;
        repeat (20000) begin
            @(posedge ref_clk);
            k += int'(po !== q[0]);
            q[0] = po;
        end
        chk("nco_toggles", 32'(k - 128 * int'(pct[0]) / 1000) >> 1, 0);
        bus(4'h6, 1'b1, 32'h7);
        repeat (8) begin
            enc <= 1'($urandom);
            repeat (6) @(posedge ref_clk);
            chk("enc_mirror", po, enc);
            fwd <= 1'($urandom);
            rev <= 1'($urandom);
            repeat (6) @(posedge ref_clk);
            chk("dir", {df, dr}, {fwd & ~rev, rev & ~fwd});
        end
        results();
    end
endmodule
